// ==== hw/pulse_timing_consts.svh ====
// Offsets, field positions, reset values and timing figures of the phase timer
// Contract
// - The second-emitter sample window opens when the period timer reaches its 16-bit start count.
// - The second-emitter sample window closes at the end count held at offset 02h.
// - The second emitter turns on at the on count held at offset 03h.
// - The second emitter turns off at the off count held at offset 04h.
// - The second ambient window opens and closes at the counts held at offsets 05h and 06h.
// - The first-emitter sample window opens and closes at the counts held at offsets 07h and 08h.
// - The first emitter turns on and off at the counts held at offsets 09h and 0Ah.
// - The first ambient window opens at the start count held at offset 0Bh.
// - Every count is a number of 4 MHz timing-clock cycles from the start of the period.
// - Every count register clears to zero on reset.
// - The timer is held in reset while the timer hold bit is one and runs only while it is zero.
`ifndef PULSE_TIMING_CONSTS_SVH
`define PULSE_TIMING_CONSTS_SVH

`define REG_CONTROL              8'h00
`define REG_SECOND_SAMPLE_START  8'h01
`define REG_SECOND_SAMPLE_END    8'h02
`define REG_SECOND_ON            8'h03
`define REG_SECOND_OFF           8'h04
`define REG_SECOND_AMBIENT_START 8'h05
`define REG_SECOND_AMBIENT_END   8'h06
`define REG_FIRST_SAMPLE_START   8'h07
`define REG_FIRST_SAMPLE_END     8'h08
`define REG_FIRST_ON             8'h09
`define REG_FIRST_OFF            8'h0A
`define REG_FIRST_AMBIENT_START  8'h0B
`define REG_FIRST_AMBIENT_END    8'h0C
`define REG_PERIOD_LENGTH        8'h20

`define CTRL_TIMER_HOLD_BIT      1
`define CTRL_SOFT_RESET_BIT      3

`define COUNT_RESET              16'h0000
`define PERIOD_RESET             16'h0000
`define READ_PAD                 8'h00

`define SYS_CLK_KHZ              16'd50000
`define TIMING_CLK_KHZ           16'd4000

`endif

// ==== hw/pulse_timing_pkg.sv ====
// Types shared by the phase timer files
package pulse_timing_pkg;
	typedef logic [15:0] count_t;
	typedef logic [23:0] word_t;
	typedef enum logic [2:0] {
		PH_SECOND_SAMPLE,
		PH_SECOND_ON,
		PH_SECOND_AMBIENT,
		PH_FIRST_SAMPLE,
		PH_FIRST_ON,
		PH_FIRST_AMBIENT
	} phase_e;
	localparam int PHASES = 6;
endpackage

// ==== hw/period_timer.sv ====
// Period timer stepped by a fractional 4 MHz tick derived from the system clock
`timescale 1ns/1ps
`include "pulse_timing_consts.svh"
module period_timer (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    ce_i,
	input  wire logic                    hold_i,
	input  wire pulse_timing_pkg::count_t period_i,
	output logic                         tick_o,
	output pulse_timing_pkg::count_t     count_o
);
	logic [15:0] acc_q;
	logic [15:0] acc_d;
	logic [16:0] acc_sum;
	logic        tick_d;
	logic [4:0]  gap_q;
	pulse_timing_pkg::count_t count_d;

	// Fractional tick
	// Ratio is 12.5, so ticks alternate 12 and 13 cycles; jitter traded for no PLL
	assign acc_sum = {1'b0, acc_q} + {1'b0, `TIMING_CLK_KHZ};
	assign tick_d  = !hold_i && (acc_sum >= {1'b0, `SYS_CLK_KHZ});
	assign acc_d   = hold_i ? 16'h0000 :
		tick_d ? 16'(acc_sum - {1'b0, `SYS_CLK_KHZ}) : acc_sum[15:0];

	assign count_d = hold_i ? 16'h0000 :
		!tick_d ? count_o :
		(count_o >= period_i) ? 16'h0000 : 16'(count_o + 16'h0001);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_q   <= 16'h0000;
			tick_o  <= 1'b0;
			count_o <= 16'h0000;
		end else if (ce_i) begin
			acc_q   <= acc_d;
			tick_o  <= tick_d;
			count_o <= count_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gap_q <= 5'h00;
		end else if (ce_i) begin
			gap_q <= (hold_i || tick_d) ? 5'h00 : 5'(gap_q + 5'h01);
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	tick_spacing_a: assert property (ce_i && tick_d |-> gap_q inside {5'd11, 5'd12})
		else $error("timing tick spacing wrong");
	hold_clears_a: assert property (ce_i && hold_i |=> count_o == 16'h0000 && !tick_o)
		else $error("timer not held at zero");
	period_wrap_a: assert property (ce_i && tick_d && count_o >= period_i && !hold_i
		|=> count_o == 16'h0000)
		else $error("timer did not wrap");
	count_step_a: assert property (ce_i && tick_d && count_o < period_i && !hold_i
		|=> count_o == $past(count_o) + 16'h0001)
		else $error("timer did not step");
	wrap_seen_c: cover property (ce_i && tick_d && count_o == period_i && period_i != 16'h0000);
endmodule // period_timer

// ==== hw/phase_window.sv ====
// One phase output, on while the timer lies between its start and end counts
`timescale 1ns/1ps
module phase_window (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    ce_i,
	input  wire logic                    hold_i,
	input  wire pulse_timing_pkg::count_t count_i,
	input  wire pulse_timing_pkg::count_t start_i,
	input  wire pulse_timing_pkg::count_t end_i,
	output logic                         active_o
);
	logic in_window;

	// Inclusive window
	// Start above end gives an empty window; no wrap-around phases
	assign in_window = !hold_i && (count_i >= start_i) && (count_i <= end_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_o <= 1'b0;
		end else if (ce_i) begin
			active_o <= in_window;
		end
	end
endmodule // phase_window

// ==== hw/pulse_phase_timing_compare.sv ====
// Phase timing compare block: count registers, period timer and six phase outputs
`timescale 1ns/1ps
`include "pulse_timing_consts.svh"
module pulse_phase_timing_compare (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     ce_i,
	input  wire logic                     wr_en_i,
	input  wire logic                     rd_en_i,
	input  wire logic [7:0]               addr_i,
	input  wire pulse_timing_pkg::word_t  wdata_i,
	output pulse_timing_pkg::word_t       rdata_o,
	output logic                          rvalid_o,
	output logic                          second_sample_o,
	output logic                          second_emitter_on_o,
	output logic                          second_ambient_o,
	output logic                          first_sample_o,
	output logic                          first_emitter_on_o,
	output logic                          first_ambient_o,
	output logic                          timer_tick_o,
	output pulse_timing_pkg::count_t      timer_count_o
);
	localparam int ENTRIES = 16;
	localparam int FIRST_COUNT = 1;
	localparam int LAST_COUNT = 12;

	pulse_timing_pkg::count_t count_q [0:ENTRIES-1];
	pulse_timing_pkg::count_t period_length_count_q;
	logic                     timer_hold_reset_q;
	pulse_timing_pkg::word_t  rdata_d;
	logic [pulse_timing_pkg::PHASES-1:0] phase_on;

	// Decode
	logic ctrl_hit;
	logic period_hit;
	logic count_hit;
	logic ctrl_write;
	logic soft_reset;
	logic hold_d;
	logic period_write;
	logic [3:0] entry_idx;

	assign entry_idx    = addr_i[3:0];
	assign ctrl_hit     = (addr_i == `REG_CONTROL);
	assign period_hit   = (addr_i == `REG_PERIOD_LENGTH);
	assign count_hit    = (addr_i >= `REG_SECOND_SAMPLE_START) &&
		(addr_i <= `REG_FIRST_AMBIENT_END);
	assign ctrl_write   = wr_en_i && ctrl_hit;
	// Self-clearing: no stored bit, so the strobe acts once per write
	assign soft_reset   = ctrl_write && wdata_i[`CTRL_SOFT_RESET_BIT];
	assign period_write = wr_en_i && period_hit && !soft_reset;

	assign hold_d = soft_reset ? 1'b0 :
		ctrl_write ? wdata_i[`CTRL_TIMER_HOLD_BIT] : timer_hold_reset_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_hold_reset_q <= 1'b0;
		end else if (ce_i) begin
			timer_hold_reset_q <= hold_d;
		end
	end

	// Count register file, one flop entry per offset
	genvar gi;
	generate
		for (gi = 0; gi < ENTRIES; gi++) begin : g_entry
			pulse_timing_pkg::count_t entry_d;
			if (gi >= FIRST_COUNT && gi <= LAST_COUNT) begin : g_used
				logic entry_write;
				assign entry_write = wr_en_i && count_hit && (entry_idx == 4'(gi));
				// Low 16 bits only
				// Upper byte must be zero from software, so it is simply dropped
				assign entry_d = soft_reset ? `COUNT_RESET :
					entry_write ? wdata_i[15:0] : count_q[gi];
			end else begin : g_unused
				assign entry_d = `COUNT_RESET;
			end
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					count_q[gi] <= `COUNT_RESET;
				end else if (ce_i) begin
					count_q[gi] <= entry_d;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			period_length_count_q <= `PERIOD_RESET;
		end else if (ce_i) begin
			if (soft_reset) begin
				period_length_count_q <= `PERIOD_RESET;
			end else if (period_write) begin
				period_length_count_q <= wdata_i[15:0];
			end
		end
	end

	// Read port; control is write-only and reads as zero like unmapped offsets
	pulse_timing_pkg::count_t rd_value;
	assign rd_value = count_hit ? count_q[entry_idx] :
		period_hit ? period_length_count_q : 16'h0000;
	assign rdata_d = {`READ_PAD, rd_value};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o  <= 24'h000000;
			rvalid_o <= 1'b0;
		end else if (ce_i) begin
			rvalid_o <= rd_en_i;
			if (rd_en_i) begin
				rdata_o <= rdata_d;
			end
		end
	end

	period_timer u_timer (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.ce_i     (ce_i),
		.hold_i   (timer_hold_reset_q),
		.period_i (period_length_count_q),
		.tick_o   (timer_tick_o),
		.count_o  (timer_count_o)
	);

	// Phase compares
	// Phase p takes its start from entry 2p+1 and its end from entry 2p+2
	generate
		for (gi = 0; gi < pulse_timing_pkg::PHASES; gi++) begin : g_phase
			phase_window u_window (
				.clk_i    (clk_i),
				.rst_i    (rst_i),
				.ce_i     (ce_i),
				.hold_i   (timer_hold_reset_q),
				.count_i  (timer_count_o),
				.start_i  (count_q[2*gi+1]),
				.end_i    (count_q[2*gi+2]),
				.active_o (phase_on[gi])
			);
		end
	endgenerate

	assign second_sample_o     = phase_on[pulse_timing_pkg::PH_SECOND_SAMPLE];
	assign second_emitter_on_o = phase_on[pulse_timing_pkg::PH_SECOND_ON];
	assign second_ambient_o    = phase_on[pulse_timing_pkg::PH_SECOND_AMBIENT];
	assign first_sample_o      = phase_on[pulse_timing_pkg::PH_FIRST_SAMPLE];
	assign first_emitter_on_o  = phase_on[pulse_timing_pkg::PH_FIRST_ON];
	assign first_ambient_o     = phase_on[pulse_timing_pkg::PH_FIRST_AMBIENT];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	second_start_a: assert property (ce_i && !timer_hold_reset_q &&
		timer_count_o == count_q[1] && count_q[1] <= count_q[2]
		|=> second_sample_o)
		else $error("second sample window did not open");
	second_end_a: assert property (ce_i && timer_count_o > count_q[2]
		|=> !second_sample_o)
		else $error("second sample window did not close");
	second_on_a: assert property (ce_i && !timer_hold_reset_q &&
		timer_count_o == count_q[3] && count_q[3] <= count_q[4]
		|=> second_emitter_on_o)
		else $error("second emitter did not turn on");
	second_off_a: assert property (ce_i && timer_count_o > count_q[4]
		|=> !second_emitter_on_o)
		else $error("second emitter did not turn off");
	second_ambient_a: assert property (ce_i &&
		(timer_count_o < count_q[5] || timer_count_o > count_q[6])
		|=> !second_ambient_o)
		else $error("second ambient window outside its counts");
	first_sample_a: assert property (ce_i && !timer_hold_reset_q &&
		timer_count_o >= count_q[7] && timer_count_o <= count_q[8]
		|=> first_sample_o)
		else $error("first sample window wrong");
	first_off_a: assert property (ce_i &&
		(timer_count_o > count_q[10] || timer_count_o < count_q[9])
		|=> !first_emitter_on_o)
		else $error("first emitter on outside its counts");
	first_ambient_a: assert property (ce_i && !timer_hold_reset_q &&
		timer_count_o == count_q[11] && count_q[11] <= count_q[12]
		|=> first_ambient_o)
		else $error("first ambient window did not open");
	hold_quiet_a: assert property (ce_i && timer_hold_reset_q
		|=> phase_on == '0 ##1 (!ce_i || timer_count_o == 16'h0000 || !timer_hold_reset_q))
		else $error("phases active while timer held");
	regs_cleared_a: assert property (@(posedge clk_i) disable iff (1'b0)
		rst_i |=> count_q[1] == 16'h0000 && count_q[12] == 16'h0000 &&
		period_length_count_q == 16'h0000)
		else $error("count registers not cleared by reset");
	upper_zero_a: assert property (rvalid_o |-> rdata_o[23:16] == 8'h00)
		else $error("read data upper byte not zero");
	// Clock enable low must freeze timer and phases
	ce_freeze_a: assert property (!ce_i |=> $stable(timer_count_o) && $stable(phase_on))
		else $error("timer state moved while clock enable low");

	second_window_c: cover property (ce_i ##1 !second_sample_o ##1 second_sample_o);
	first_ambient_c: cover property (first_ambient_o && first_emitter_on_o == 1'b0);
	readback_c: cover property (rvalid_o && rdata_o != 24'h000000);
endmodule // pulse_phase_timing_compare

// ==== bench/tb_pulse_phase_timing_compare.sv ====
// Self-checking bench for the phase timing compare block
`timescale 1ns/1ps
module tb_pulse_phase_timing_compare;
	logic                     clk_i, rst_i, ce_i, wr_en_i, rd_en_i;
	logic [7:0]               addr_i;
	pulse_timing_pkg::word_t  wdata_i, rdata_o, got, v1;
	logic                     rvalid_o, timer_tick_o;
	pulse_timing_pkg::count_t timer_count_o, prev_c, period, v;
	pulse_timing_pkg::count_t st [6];
	pulse_timing_pkg::count_t en [6];
	logic [5:0]               ph;
	int                       bad_count, n_checks, seed, gap, mon, first;

	pulse_phase_timing_compare dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.rdata_o(rdata_o), .rvalid_o(rvalid_o), .second_sample_o(ph[0]),
		.second_emitter_on_o(ph[1]), .second_ambient_o(ph[2]), .first_sample_o(ph[3]),
		.first_emitter_on_o(ph[4]), .first_ambient_o(ph[5]),
		.timer_tick_o(timer_tick_o), .timer_count_o(timer_count_o));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	function automatic logic in_win(pulse_timing_pkg::count_t c, s, e);
		return (s <= c) && (c <= e);
	endfunction

	function automatic pulse_timing_pkg::count_t nxt(pulse_timing_pkg::count_t c);
		return (c == period) ? 16'h0000 : c + 16'h0001;
	endfunction

	task automatic chk_w(input pulse_timing_pkg::word_t g, input pulse_timing_pkg::word_t e);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: word %h, expected %h", $time, g, e);
		end
	endtask

	task automatic chk_b(input logic g, input logic e);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: flag %b, expected %b", $time, g, e);
		end
	endtask

	// Every task starts and ends just after a rising edge
	task automatic wr(input logic [7:0] a, input pulse_timing_pkg::word_t d);
		wr_en_i = 1'b1;
		addr_i = a;
		wdata_i = d;
		@(posedge clk_i);
		#2 wr_en_i = 1'b0;
		// Idle edge, so a following call never re-raises the strobe in one step
		@(posedge clk_i);
		#2;
	endtask

	task automatic rd(input logic [7:0] a);
		rd_en_i = 1'b1;
		addr_i = a;
		@(posedge clk_i);
		#2 rd_en_i = 1'b0;
		chk_b(rvalid_o, 1'b1);
		got = rdata_o;
		@(posedge clk_i);
		#2;
		// Valid stands one cycle only
		chk_b(rvalid_o, 1'b0);
	endtask

	task automatic rd_zero_all();
		for (int i = 0; i < 13; i++) begin
			rd((i == 12) ? 8'h20 : 8'(i + 1));
			chk_w(got, 24'h000000);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Phase lags the count by one clock, so it is judged against the previous count
	always begin
		@(posedge clk_i);
		#1;
		if (mon) begin
			for (int p = 0; p < 6; p++)
				chk_b(ph[p], in_win(prev_c, st[p], en[p]));
			if (timer_tick_o) begin
				if (!first)
					chk_b(gap == 12 || gap == 13, 1'b1);
				chk_w({8'h00, timer_count_o}, {8'h00, nxt(prev_c)});
				first = 0;
				gap = 0;
			end else
				chk_w({8'h00, timer_count_o}, {8'h00, prev_c});
			gap++;
		end
		prev_c = timer_count_o;
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		$display("Error at %0t: run timed out", $time);
		tally_and_finish();
	end

	initial begin
		rst_i = 1'b1;
		ce_i = 1'b1;
		wr_en_i = 1'b0;
		rd_en_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 24'h000000;
		seed = 18;
		mon = 0;
		repeat (2) @(posedge clk_i);
		#2 rst_i = 1'b0;
		repeat (2) @(posedge clk_i);
		#2;
		// All counts zero, so every window covers count zero
		chk_w({18'h00000, ph}, 24'h00003F);
		chk_w({8'h00, timer_count_o}, 24'h000000);
		rd_zero_all();
		$display("test reset done");
		for (int i = 0; i < 13; i++) begin
			v = 16'($random(seed));
			// Upper byte kept zero as software must
			wr((i == 12) ? 8'h20 : 8'(i + 1), {8'h00, v});
			rd((i == 12) ? 8'h20 : 8'(i + 1));
			chk_w(got, {8'h00, v});
			if (i == 0)
				v1 = {8'h00, v};
		end
		ce_i = 1'b0;
		wr(8'h01, 24'h001234);
		ce_i = 1'b1;
		rd(8'h01);
		chk_w(got, v1);
		wr(8'h30, 24'h00ABCD);
		rd(8'h30);
		chk_w(got, 24'h000000);
		rd(8'h00);
		chk_w(got, 24'h000000);
		$display("test registers done");
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#2 rst_i = 1'b0;
		rd_zero_all();
		$display("test mid reset done");
		period = 16'd20 + 16'($random(seed) & 7);
		for (int p = 0; p < 6; p++) begin
			st[p] = 16'($unsigned($random(seed)) % period);
			en[p] = st[p] + 16'($random(seed) & 7);
		end
		// Corners: full-period window and an empty one
		st[0] = 16'h0000;
		en[0] = period;
		st[1] = 16'h0005;
		en[1] = 16'h0003;
		for (int p = 0; p < 6; p++) begin
			wr(8'(2 * p + 1), {8'h00, st[p]});
			wr(8'(2 * p + 2), {8'h00, en[p]});
		end
		wr(8'h20, {8'h00, period});
		repeat (2) @(posedge clk_i);
		#2;
		first = 1;
		mon = 1;
		repeat (2 * (period + 1) * 13) @(posedge clk_i);
		#2 mon = 0;
		$display("test timer done");
		ce_i = 1'b0;
		v = timer_count_o;
		v1 = {18'h00000, ph};
		repeat (20) begin
			@(posedge clk_i);
			#2;
			chk_w({8'h00, timer_count_o}, {8'h00, v});
			chk_w({18'h00000, ph}, v1);
		end
		ce_i = 1'b1;
		$display("test freeze done");
		wr(8'h00, 24'h000002);
		repeat (3) @(posedge clk_i);
		#2;
		repeat (30) begin
			@(posedge clk_i);
			#2;
			chk_w({8'h00, timer_count_o}, 24'h000000);
			chk_b(timer_tick_o, 1'b0);
			chk_w({18'h00000, ph}, 24'h000000);
		end
		wr(8'h00, 24'h000000);
		repeat (15) @(posedge clk_i);
		#2;
		chk_b(timer_count_o != 16'h0000, 1'b1);
		$display("test hold done");
		wr(8'h00, 24'h000008);
		rd_zero_all();
		$display("test soft reset done");
		tally_and_finish();
	end
endmodule // tb_pulse_phase_timing_compare
